// ---- src/opcode_exec_defs.svh ----
`ifndef OPCODE_EXEC_DEFS_SVH
`define OPCODE_EXEC_DEFS_SVH

// ============================================================
// apb register map (byte addresses)
`define REG_CTRL 12'h000
`define REG_INSTR 12'h004
`define REG_STATUS 12'h008
`define REG_PC 12'h00c
`define REG_RAMPTR 12'h010
`define REG_ACC_X 12'h014
`define REG_ACC_Y 12'h018
`define REG_ACC_Z 12'h01c
`define REG_ACC_R 12'h020
`define REG_REINIT_CNT 12'h024

// ============================================================
// instruction word layout in REG_INSTR
`define INSTR_OP_LSB 0
`define INSTR_OP_MSB 2
`define INSTR_SEL_LSB 4
`define INSTR_SEL_MSB 5
`define INSTR_ABS_BIT 6
`define INSTR_TGT_LSB 8
`define INSTR_TGT_MSB 20

// ============================================================
// opcode encodings
`define OP_BRANCH 3'h1
`define OP_INCR 3'h2
`define OP_RAMSTEP 3'h3
`define OP_REINIT 3'h4
`define OP_INVERT 3'h5

// ============================================================
// cycle counts and instruction lengths
`define CYC_BR_REL 3'h3
`define CYC_BR_ABS 3'h4
`define CYC_INCR 3'h1
`define CYC_RAMSTEP 3'h1
`define CYC_REINIT 3'h3
`define CYC_INVERT 3'h2
`define LEN_BR_REL 13'h0002
`define LEN_BR_ABS 13'h0003
`define LEN_ONE 13'h0001
`define LEN_TWO 13'h0002

// ============================================================
// flag bit positions in REG_STATUS
`define FLAG_C 0
`define FLAG_O 1
`define FLAG_S 2
`define FLAG_Z 3
`define STATUS_BUSY 8

`endif

// ---- src/opcode_exec_pkg.sv ----
`default_nettype none
package opcode_exec_pkg;
    typedef enum logic [1:0] {
        SEL_X,
        SEL_Y,
        SEL_Z,
        SEL_R
    } acc_sel_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DONE
    } exec_state_t;
endpackage
`default_nettype wire

// ---- src/working_register_alu.sv ----
`default_nettype none
module working_register_alu #(
    parameter int WIDTH = 24
) (
    input wire logic [WIDTH-1:0] operand,
    input wire logic do_invert,
    output logic [WIDTH-1:0] result,
    output logic carry,
    output logic overflow,
    output logic sign,
    output logic zero
);
    logic [WIDTH:0] sum;
    assign sum = {1'b0, operand} + {{WIDTH{1'b0}}, 1'b1};
    assign result = do_invert ? ~operand : sum[WIDTH-1:0];
    assign carry = sum[WIDTH];
    // signed overflow only when max positive wraps
    assign overflow = ~operand[WIDTH-1] & sum[WIDTH-1];
    assign sign = result[WIDTH-1];
    assign zero = (result == '0);
endmodule // working_register_alu
`default_nettype wire

// ---- src/cpu_opcode_subset_exec.sv ----
`include "opcode_exec_defs.svh"
`default_nettype none
module cpu_opcode_subset_exec #(
    parameter int WIDTH = 24,
    parameter int PC_WIDTH = 13,
    parameter int RAM_PTR_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic converter_reinit,
    output logic [RAM_PTR_WIDTH-1:0] ram_ptr,
    output logic [PC_WIDTH-1:0] pc,
    output logic [3:0] arith_flag_set
);
    import opcode_exec_pkg::*;

    // ========================================================
    // state
    exec_state_t state_r, state_nxt;
    logic [31:0] instr_r;
    logic [2:0] cyc_r, cyc_nxt;
    logic [PC_WIDTH-1:0] pc_r, pc_nxt;
    logic [RAM_PTR_WIDTH-1:0] ram_ptr_r, ram_ptr_nxt;
    logic [3:0] flags_r, flags_nxt;
    logic [WIDTH-1:0] acc_r [4];
    logic [WIDTH-1:0] acc_nxt;
    logic acc_we;
    logic reinit_r, reinit_nxt;
    logic [15:0] reinit_cnt_r;

    // ========================================================
    // apb decode
    wire apb_access = psel & penable;
    wire apb_wr = apb_access & pwrite;
    wire busy = (state_r != ST_IDLE);
    wire wr_ctrl = apb_wr & (paddr == `REG_CTRL);
    wire wr_instr = apb_wr & (paddr == `REG_INSTR) & ~busy;
    wire wr_pc = apb_wr & (paddr == `REG_PC) & ~busy;
    wire wr_ramptr = apb_wr & (paddr == `REG_RAMPTR) & ~busy;
    wire wr_status = apb_wr & (paddr == `REG_STATUS) & ~busy;
    wire wr_acc_x = apb_wr & (paddr == `REG_ACC_X) & ~busy;
    wire wr_acc_y = apb_wr & (paddr == `REG_ACC_Y) & ~busy;
    wire wr_acc_z = apb_wr & (paddr == `REG_ACC_Z) & ~busy;
    wire wr_acc_r = apb_wr & (paddr == `REG_ACC_R) & ~busy;
    wire start = wr_ctrl & pwdata[0] & ~busy;
    wire addr_ok = (paddr == `REG_CTRL) | (paddr == `REG_INSTR)
        | (paddr == `REG_STATUS) | (paddr == `REG_PC)
        | (paddr == `REG_RAMPTR) | (paddr == `REG_ACC_X)
        | (paddr == `REG_ACC_Y) | (paddr == `REG_ACC_Z)
        | (paddr == `REG_ACC_R) | (paddr == `REG_REINIT_CNT);

    assign pready = 1'b1;
    assign pslverr = apb_access & ~addr_ok;

    // ========================================================
    // instruction fields
    wire [2:0] op = instr_r[`INSTR_OP_MSB:`INSTR_OP_LSB];
    wire [1:0] sel_bits = instr_r[`INSTR_SEL_MSB:`INSTR_SEL_LSB];
    wire is_abs = instr_r[`INSTR_ABS_BIT];
    wire [PC_WIDTH-1:0] label_field =
        instr_r[`INSTR_TGT_MSB:`INSTR_TGT_LSB];
    acc_sel_t sel;
    assign sel = acc_sel_t'(sel_bits);

    // absolute form carries the address; relative form an offset
    wire [PC_WIDTH-1:0] tgt_rel = pc_r + label_field;
    wire [PC_WIDTH-1:0] target = is_abs ? label_field : tgt_rel;
    wire [PC_WIDTH-1:0] br_len = is_abs ? `LEN_BR_ABS : `LEN_BR_REL;

    logic [2:0] op_cycles;
    always_comb begin
        case (op)
            `OP_BRANCH: op_cycles = is_abs ? `CYC_BR_ABS : `CYC_BR_REL;
            `OP_INCR: op_cycles = `CYC_INCR;
            `OP_RAMSTEP: op_cycles = `CYC_RAMSTEP;
            `OP_REINIT: op_cycles = `CYC_REINIT;
            `OP_INVERT: op_cycles = `CYC_INVERT;
            default: op_cycles = 3'h1;
        endcase
    end

    // ========================================================
    // datapath
    logic [WIDTH-1:0] alu_res;
    logic alu_c, alu_o, alu_s, alu_z;
    working_register_alu #(
        .WIDTH(WIDTH)
    ) u_alu (
        .operand(acc_r[sel]),
        .do_invert(op == `OP_INVERT),
        .result(alu_res),
        .carry(alu_c),
        .overflow(alu_o),
        .sign(alu_s),
        .zero(alu_z)
    );

    wire last = busy & (cyc_r == 3'h1);

    // ========================================================
    // sequencer
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        pc_nxt = pc_r;
        ram_ptr_nxt = ram_ptr_r;
        flags_nxt = flags_r;
        acc_nxt = alu_res;
        acc_we = 1'b0;
        reinit_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_EXEC;
                    cyc_nxt = op_cycles;
                end
            end
            ST_EXEC: begin
                cyc_nxt = cyc_r - 3'h1;
                if (last) begin
                    state_nxt = ST_DONE;
                    case (op)
                        `OP_BRANCH: begin
                            if (!flags_r[`FLAG_S]) begin
                                pc_nxt = target;
                            end else begin
                                pc_nxt = pc_r + br_len;
                            end
                        end
                        `OP_INCR: begin
                            acc_we = 1'b1;
                            flags_nxt = {alu_z, alu_s, alu_o, alu_c};
                            pc_nxt = pc_r + `LEN_ONE;
                        end
                        `OP_RAMSTEP: begin
                            ram_ptr_nxt = ram_ptr_r + 1'b1;
                            pc_nxt = pc_r + `LEN_ONE;
                        end
                        `OP_REINIT: begin
                            reinit_nxt = 1'b1;
                            pc_nxt = pc_r + `LEN_TWO;
                        end
                        `OP_INVERT: begin
                            acc_we = 1'b1;
                            flags_nxt[`FLAG_S] = alu_s;
                            flags_nxt[`FLAG_Z] = alu_z;
                            pc_nxt = pc_r + `LEN_TWO;
                        end
                        default: pc_nxt = pc_r + `LEN_ONE;
                    endcase
                end
            end
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cyc_r <= 3'h0;
            reinit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            reinit_r <= reinit_nxt;
        end
    end

    // ========================================================
    // architectural registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= '0;
            ram_ptr_r <= '0;
            flags_r <= 4'h0;
            instr_r <= 32'h0000_0000;
        end else begin
            pc_r <= wr_pc ? pwdata[PC_WIDTH-1:0] : pc_nxt;
            ram_ptr_r <= wr_ramptr ? pwdata[RAM_PTR_WIDTH-1:0]
                : ram_ptr_nxt;
            flags_r <= wr_status ? pwdata[3:0] : flags_nxt;
            if (wr_instr) begin
                instr_r <= pwdata;
            end
        end
    end

    wire [3:0] acc_wr_sw = {wr_acc_r, wr_acc_z, wr_acc_y, wr_acc_x};
    for (genvar i = 0; i < 4; i++) begin : g_acc
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc_r[i] <= '0;
            end else if (acc_wr_sw[i]) begin
                acc_r[i] <= pwdata[WIDTH-1:0];
            end else if (acc_we && (sel_bits == 2'(i))) begin
                acc_r[i] <= acc_nxt;
            end
        end
    end

    // reinit touches no configuration; it pulses converter_reinit, advances pc by two and counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reinit_cnt_r <= 16'h0000;
        end else if (reinit_r) begin
            reinit_cnt_r <= reinit_cnt_r + 16'h0001;
        end
    end

    // ========================================================
    // read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            `REG_CTRL: rdata = {31'h0000_0000, busy};
            `REG_INSTR: rdata = instr_r;
            `REG_STATUS: begin
                rdata[3:0] = flags_r;
                rdata[`STATUS_BUSY] = busy;
            end
            `REG_PC: rdata[PC_WIDTH-1:0] = pc_r;
            `REG_RAMPTR: rdata[RAM_PTR_WIDTH-1:0] = ram_ptr_r;
            `REG_ACC_X: rdata[WIDTH-1:0] = acc_r[0];
            `REG_ACC_Y: rdata[WIDTH-1:0] = acc_r[1];
            `REG_ACC_Z: rdata[WIDTH-1:0] = acc_r[2];
            `REG_ACC_R: rdata[WIDTH-1:0] = acc_r[3];
            `REG_REINIT_CNT: rdata[15:0] = reinit_cnt_r;
            default: rdata = 32'h0000_0000;
        endcase
    end
    assign prdata = rdata;

    assign converter_reinit = reinit_r;
    assign ram_ptr = ram_ptr_r;
    assign pc = pc_r;
    assign arith_flag_set = flags_r;
endmodule // cpu_opcode_subset_exec
`default_nettype wire

// ---- test/cpu_opcode_subset_exec_properties.sv ----
`default_nettype none
module cpu_opcode_subset_exec_properties #(
    parameter int WIDTH = 24,
    parameter int PC_WIDTH = 13,
    parameter int RAM_PTR_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic converter_reinit,
    input wire logic [RAM_PTR_WIDTH-1:0] ram_ptr,
    input wire logic [PC_WIDTH-1:0] pc,
    input wire logic [3:0] arith_flag_set
);
    // ========
    // opcode start tracking
    logic [20:0] ins_r;
    wire wr = psel && penable && pwrite;
    wire go = wr && paddr == 12'h000 && pwdata[0];
    wire ab = ins_r[6];
    wire sf = arith_flag_set[2];
    wire g_br = go && ins_r[2:0] == 3'h1;
    wire g_inc = go && ins_r[2:0] == 3'h2;
    wire g_ram = go && ins_r[2:0] == 3'h3;
    wire g_ri = go && ins_r[2:0] == 3'h4;
    wire g_inv = go && ins_r[2:0] == 3'h5;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ins_r <= '0;
        end else if (wr && paddr == 12'h004) begin
            ins_r <= pwdata[20:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence reinit_pulse;
        !converter_reinit [*3] ##1 converter_reinit ##1 !converter_reinit;
    endsequence
    a_reinit_pulse: assert property (
        g_ri |=> reinit_pulse) else $error("reinit pulse late");
    a_reinit_cause: assert property (
        converter_reinit |-> $past(g_ri, 4)) else $error("stray reinit");
    a_ramstep_adds: assert property (
        g_ram |-> ##2 ram_ptr == RAM_PTR_WIDTH'($past(ram_ptr, 2) + 1'b1))
        else $error("ram step wrong");
    a_ramstep_flags: assert property (
        g_ram |-> ##2 arith_flag_set == $past(arith_flag_set, 2))
        else $error("ram step flags");
    a_branch_abs: assert property (
        g_br && ab && !sf |=> $stable(pc) [*4] ##1 pc == ins_r[20:8])
        else $error("abs branch wrong");
    a_branch_rel: assert property (
        g_br && !ab && !sf |=> $stable(pc) [*3]
        ##1 pc == PC_WIDTH'($past(pc, 4) + ins_r[20:8]))
        else $error("rel branch wrong");
    a_branch_skip: assert property (
        g_br && sf && !ab |-> ##4 pc == PC_WIDTH'($past(pc, 4) + 2'h2))
        else $error("branch not skipped");
    a_branch_flags: assert property (
        g_br |-> ##5 arith_flag_set == $past(arith_flag_set, 5))
        else $error("branch flags");
    a_invert_keeps: assert property (
        g_inv |-> ##3 ((arith_flag_set ^ $past(arith_flag_set, 3)) & 4'h3)
        == 4'h0) else $error("invert c o");
    a_incr_pc: assert property (
        g_inc |-> ##2 pc == PC_WIDTH'($past(pc, 2) + 1'b1))
        else $error("incr pc");
endmodule // cpu_opcode_subset_exec_properties
bind cpu_opcode_subset_exec cpu_opcode_subset_exec_properties #(
    .WIDTH(WIDTH), .PC_WIDTH(PC_WIDTH), .RAM_PTR_WIDTH(RAM_PTR_WIDTH)
) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .converter_reinit(converter_reinit),
    .ram_ptr(ram_ptr), .pc(pc), .arith_flag_set(arith_flag_set)
);
`default_nettype wire

// ---- test/cpu_opcode_subset_exec_bench.sv ----
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module cpu_opcode_subset_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, c_re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] ram_ptr;
    logic [12:0] pc;
    logic [3:0] arith_flag_set;
    int num_errors, tests_run, rc;
    logic [23:0] acc [4];
    logic [3:0] fl;
    logic [12:0] pcm;
    logic [7:0] rp;
    cpu_opcode_subset_exec u_cpu_opcode_subset_exec (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .converter_reinit(c_re),
        .ram_ptr(ram_ptr), .pc(pc), .arith_flag_set(arith_flag_set)
    );
    // ========
    // clock and bus tasks
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic results();
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int k;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // answer settles mid-cycle and holds until the sampling edge
        do begin
            @(negedge pclk);
            rdy = pready;
            q = prdata;
            e = pslverr;
            @(posedge pclk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, x)
    endtask
    task automatic op(input int c, input int s, input int ab,
        input logic [12:0] t);
        int n;
        logic [12:0] p0;
        logic [24:0] v;
        wr(12'h004, 32'(c) | 32'(s) << 4 | 32'(ab) << 6 | 32'(t) << 8);
        p0 = pc;
        wr(12'h000, 32'h0000_0001);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (pc === p0 && n < 8);
        `CHK(n, c == 1 ? 3 + ab : c == 4 ? 3 : c == 5 ? 2 : 1)
        case (c)
            1: pcm = fl[2] ? pcm + 13'(2 + ab) : ab ? t : pcm + t;
            2: begin
                v = {1'b0, acc[s]} + 25'h1;
                fl = {v[23:0] == 0, v[23], acc[s] == 24'h7f_ffff, v[24]};
                acc[s] = v[23:0];
            end
            3: rp++;
            4: rc++;
            5: begin
                acc[s] = ~acc[s];
                fl[3:2] = {acc[s] == 0, acc[s][23]};
            end
        endcase
        if (c > 1) pcm = pcm + 13'(c < 4 ? 1 : 2);
        repeat (4) @(posedge pclk);
        rd_chk(12'h000, 32'h0);
        `CHK(pc, pcm)
        `CHK(ram_ptr, rp)
        `CHK(arith_flag_set, fl)
        for (int i = 0; i < 4; i++) rd_chk(12'h014 + 12'(4 * i), acc[i]);
        rd_chk(12'h024, 32'(rc));
    endtask
    // ========
    // main sequence
    initial begin
        logic [12:0] t;
        logic [31:0] q;
        logic e;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {num_errors, tests_run, rc, fl, pcm, rp} = '0;
        acc = '{default: 24'h0};
        void'($urandom(53));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK({pc, ram_ptr, arith_flag_set, c_re, pready}, 27'h000_0001)
        for (int s = 0; s < 4; s++) begin
            acc[s] = 24'($urandom);
            wr(12'h014 + 12'(4 * s), 32'(acc[s]));
            op(2, s, 0, 0);
            op(5, s, 0, 0);
        end
        acc[0] = 24'h7f_ffff;
        acc[3] = 24'hff_ffff;
        wr(12'h014, 32'h007f_ffff);
        wr(12'h020, 32'h00ff_ffff);
        op(2, 0, 0, 0);
        op(2, 3, 0, 0);
        op(5, 3, 0, 0);
        fl = 4'($urandom);
        wr(12'h008, 32'(fl));
        op(3, 0, 0, 0);
        op(3, 0, 0, 0);
        op(4, 0, 0, 0);
        for (int k = 0; k < 8; k++) begin
            fl = 4'($urandom) & 4'hb | 4'(k[0]) << 2;
            wr(12'h008, 32'(fl));
            t = 13'($urandom) | 13'h0001;
            if (k[1]) t = t ^ pcm;
            op(1, 0, k[1], t);
        end
        apb(1'b0, 12'h028, 32'h0, q, e);
        `CHK({e, q}, {1'b1, 32'h0000_0000})
        results();
    end
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule // cpu_opcode_subset_exec_bench
`default_nettype wire
